/* bench/sie_model.sv */
module sie_model (
  // Clock
  input wire logic clk_i,
  // Token link
  output logic tok_valid_o,
  output ep_fifo_pkg::token_type tok_o,
  input wire logic tok_match_i,
  input wire logic [2:0] tok_ep_i,
  // Transmit stream
  output logic tx_req_o,
  output logic tx_done_o,
  output logic tx_err_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_eop_i,
  input wire logic tx_underrun_i,
  // Receive stream
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_end_o,
  output logic rx_err_o,
  input wire logic rx_overrun_i
);
  timeunit 1ns;
  timeprecision 100ps;
  import ep_fifo_pkg::*;
  // ==========================================================
  // Idle levels
  initial begin
    {tok_valid_o, tx_req_o, tx_done_o, tx_err_o} = 4'h0;
    {rx_valid_o, rx_end_o, rx_err_o} = 3'h0;
    tok_o = '0;
    rx_data_o = 8'h00;
  end
  // Token pulse; released lines show the inverse, not a stale token
  task automatic token(input logic [6:0] a, input logic [3:0] e,
                       input logic din, output logic m,
                       output logic [2:0] s);
    @(posedge clk_i);
    tok_valid_o <= 1'b1;
    tok_o <= '{addr: a, ep: e, dir_in: din};
    @(posedge clk_i);
    tok_valid_o <= 1'b0;
    tok_o <= ~tok_o;
    @(posedge clk_i);
    m = tok_match_i;
    s = tok_ep_i;
  endtask
  // One byte request; gap makes the engine slow or prompt
  task automatic fetch(input int gap, output logic [2:0] k,
                       output logic [7:0] d);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    tx_req_o <= 1'b1;
    @(posedge clk_i);
    tx_req_o <= 1'b0;
    @(posedge clk_i);
    k = {tx_valid_i, tx_eop_i, tx_underrun_i};
    d = tx_data_i;
  endtask
  // One received byte; data line scrambled once released
  task automatic put(input int gap, input logic [7:0] d,
                     output logic ov);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_data_o <= d;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~d;
    @(posedge clk_i);
    ov = rx_overrun_i;
  endtask
  // Packet end pulses: done, error, out end, out error
  task automatic fin(input logic [3:0] f);
    @(posedge clk_i);
    {tx_done_o, tx_err_o, rx_end_o, rx_err_o} <= f;
    @(posedge clk_i);
    {tx_done_o, tx_err_o, rx_end_o, rx_err_o} <= 4'h0;
  endtask
endmodule

/* bench/usb_endpoint_fifo_array_test.sv */
module usb_endpoint_fifo_array_test;
  timeunit 1ns;
  timeprecision 100ps;
  import ep_fifo_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, tv, tm, treq, tdone, terr;
  logic tval, teop, tund, rv, rend, rerr, rovr, m, ov;
  logic [7:0] adr, td, rd_b, b, d;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, r;
  logic [2:0] tep, s, k;
  token_type tok;
  logic [7:0] q[$];
  int n_mismatch, checks_done;
  // ==========================================================
  // Design and serial engine
  usb_endpoint_fifo_array i_usb_endpoint_fifo_array (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .tok_valid_i(tv), .tok_i(tok), .tok_match_o(tm),
    .tok_ep_o(tep), .tx_req_i(treq), .tx_done_i(tdone), .tx_err_i(terr),
    .tx_valid_o(tval), .tx_data_o(td), .tx_eop_o(teop),
    .tx_underrun_o(tund), .rx_valid_i(rv), .rx_data_i(rd_b),
    .rx_end_i(rend), .rx_err_i(rerr), .rx_overrun_o(rovr));
  sie_model i_sie_model (.clk_i(clk_i), .tok_valid_o(tv), .tok_o(tok),
    .tok_match_i(tm), .tok_ep_i(tep), .tx_req_o(treq), .tx_done_o(tdone),
    .tx_err_o(terr), .tx_valid_i(tval), .tx_data_i(td), .tx_eop_i(teop),
    .tx_underrun_i(tund), .rx_valid_o(rv), .rx_data_o(rd_b),
    .rx_end_o(rend), .rx_err_o(rerr), .rx_overrun_i(rovr));
  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // ==========================================================
  // Helpers
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // Classic cycle; held until ack is sampled high, bounded wait
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] dv, output logic [31:0] qv);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, dv};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      close_out();
    end
    qv = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  function automatic logic [7:0] at(input logic [7:0] base, input int sl);
    return base + 8'(4 * sl);
  endfunction
  function automatic logic [31:0] depth(input int sl);
    return sl == 0 ? 32'(DEPTH_EP0) : (sl < 5 ? 32'(DEPTH_SMALL)
                                               : 32'(DEPTH_LARGE));
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'he38ec571));
    {rst_i, cyc, stb, we, adr, wdat, sel} = {1'b1, 3'h0, 8'h00,
                                             32'h0000_0000, 4'hf};
    n_mismatch = 0;
    checks_done = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset levels: tx slots free, rx slots empty
    for (int i = 1; i < 7; i++) begin
      wb(1'b0, at(8'h60, i), 32'h0000_0000, r);
      chk(r & 32'h0000_007f, i % 2 ? depth(i) : 32'h0000_0000);
    end
    wb(1'b0, 8'hfc, 32'h0000_0000, r);
    chk(r, 32'h0000_0000);
    // Address 5; slots 1 to 4 all on endpoint 1
    wb(1'b1, 8'h00, 32'h0000_0085, r);
    for (int i = 1; i < 5; i++) wb(1'b1, at(8'h20, i), 32'h0000_0011, r);
    i_sie_model.token(7'h06, 4'h1, 1'b1, m, s);
    chk({31'h0, m}, 32'h0000_0000);
    i_sie_model.token(7'h05, 4'h7, 1'b1, m, s);
    chk({31'h0, m}, 32'h0000_0000);
    i_sie_model.token(7'h05, 4'h1, 1'b0, m, s);
    chk({28'h0, m, s}, 32'h0000_000a);
    // Disabled lower receiver hands the number to slot4
    wb(1'b1, 8'h28, 32'h0000_0001, r);
    i_sie_model.token(7'h05, 4'h1, 1'b0, m, s);
    chk({28'h0, m, s}, 32'h0000_000c);
    wb(1'b1, 8'h28, 32'h0000_0011, r);
    // Fill slot1 past full, warning threshold 4
    wb(1'b1, 8'h44, 32'h0000_0400, r);
    q.delete();
    for (int i = 0; i < 33; i++) begin
      b = 8'($urandom);
      wb(1'b1, 8'h84, {24'h0, b}, r);
      if (i < 32) q.push_back(b);
    end
    wb(1'b0, 8'h64, 32'h0000_0000, r);
    chk(r & 32'h0000_007f, 32'h0000_0000);
    wb(1'b0, 8'h04, 32'h0000_0000, r);
    chk(r & 32'h0000_0002, 32'h0000_0000);
    i_sie_model.token(7'h05, 4'h1, 1'b1, m, s);
    chk({28'h0, m, s}, 32'h0000_0009);
    for (int i = 0; i < 34; i++) begin
      // Half way through, refill while the packet is on the bus
      for (int j = 0; j < 2 && i == 16; j++) begin
        b = 8'($urandom);
        wb(1'b1, 8'h84, {24'h0, b}, r);
        q.push_back(b);
      end
      i_sie_model.fetch($urandom_range(2), k, d);
      chk({21'h0, k, d}, {21'h0, 3'b100, q[i]});
    end
    i_sie_model.fetch(0, k, d);
    chk({29'h0, k}, 32'h0000_0001);
    i_sie_model.fin(4'b1000);
    wb(1'b0, 8'h64, 32'h0000_0000, r);
    chk(r & 32'h0000_007f, 32'h0000_0020);
    wb(1'b0, 8'h04, 32'h0000_0000, r);
    chk(r & 32'h0000_0002, 32'h0000_0002);
    // Receive into slot2 until it overflows, then drain past empty
    i_sie_model.token(7'h05, 4'h1, 1'b0, m, s);
    q.delete();
    for (int i = 0; i < 33; i++) begin
      b = 8'($urandom);
      i_sie_model.put($urandom_range(2), b, ov);
      if (i < 32) q.push_back(b);
      chk({31'h0, ov}, i == 32 ? 32'h0000_0001 : 32'h0000_0000);
    end
    i_sie_model.fin(4'b0010);
    wb(1'b0, 8'h68, 32'h0000_0000, r);
    chk(r & 32'h0000_007f, 32'h0000_0020);
    wb(1'b0, 8'h04, 32'h0000_0000, r);
    chk(r & 32'h0000_0004, 32'h0000_0004);
    for (int i = 0; i < 33; i++) begin
      wb(1'b0, 8'h88, 32'h0000_0000, r);
      chk(r & 32'h0000_00ff, {24'h0, q[i < 32 ? i : 31]});
    end
    // Packet with a CRC error leaves nothing behind
    i_sie_model.token(7'h05, 4'h1, 1'b0, m, s);
    for (int i = 0; i < 5; i++) i_sie_model.put(0, 8'($urandom), ov);
    i_sie_model.fin(4'b0011);
    wb(1'b0, 8'h68, 32'h0000_0000, r);
    chk(r & 32'h0000_03ff, 32'h0000_0000);
    // Long OUT packet drained while it still arrives
    i_sie_model.token(7'h05, 4'h1, 1'b0, m, s);
    q.delete();
    for (int i = 0; i < 40; i++) begin
      b = 8'($urandom);
      i_sie_model.put(0, b, ov);
      q.push_back(b);
      chk({31'h0, ov}, 32'h0000_0000);
      if (i >= 30) begin
        wb(1'b0, 8'h88, 32'h0000_0000, r);
        chk(r & 32'h0000_00ff, {24'h0, q.pop_front()});
      end
    end
    i_sie_model.fin(4'b0010);
    wb(1'b0, 8'h68, 32'h0000_0000, r);
    chk(r & 32'h0000_03ff, 32'h0000_021e);
    // Flush a partly filled transmit FIFO
    for (int i = 0; i < 3; i++) wb(1'b1, 8'h84, 32'h0000_00a5, r);
    wb(1'b1, 8'h44, 32'h0000_0001, r);
    wb(1'b0, 8'h64, 32'h0000_0000, r);
    chk(r & 32'h0000_007f, 32'h0000_0020);
    // Iso pair: an empty lower transmit slot yields to the next
    wb(1'b1, 8'h24, 32'h0000_0031, r);
    wb(1'b1, 8'h2c, 32'h0000_0031, r);
    wb(1'b1, 8'h8c, 32'h0000_005a, r);
    i_sie_model.token(7'h05, 4'h1, 1'b1, m, s);
    chk({28'h0, m, s}, 32'h0000_000b);
    // Endpoint zero: transmit only, default address, last flag set
    wb(1'b1, 8'h20, 32'h0000_00d0, r);
    wb(1'b1, 8'h40, 32'h0000_0002, r);
    q.delete();
    for (int i = 0; i < 9; i++) begin
      b = 8'($urandom);
      wb(1'b1, 8'h80, {24'h0, b}, r);
      if (i < 8) q.push_back(b);
    end
    wb(1'b0, 8'h60, 32'h0000_0000, r);
    chk(r & 32'h0000_007f, 32'h0000_0000);
    for (int p = 0; p < 2; p++) begin
      i_sie_model.token(7'h00, 4'h0, 1'b1, m, s);
      chk({28'h0, m, s}, 32'h0000_0008);
      for (int i = 0; i < 9; i++) begin
        i_sie_model.fetch(0, k, d);
        chk({21'h0, k, i < 8 ? d : 8'h00},
            {21'h0, i < 8 ? 3'b100 : 3'b010, i < 8 ? q[i] : 8'h00});
      end
      i_sie_model.fin(p == 0 ? 4'b0100 : 4'b1000);
    end
    close_out();
  end
endmodule

/* logic/ep_fifo_pkg.sv */
package ep_fifo_pkg;
  // ==========================================================
  // Geometry
  localparam int NUM_FIFO = 7;
  localparam int PTR_W = 7;
  localparam int ADDR_W = 6;
  localparam int MEM_DEPTH = 64;
  localparam int DEPTH_EP0 = 8;
  localparam int DEPTH_SMALL = 32;
  localparam int DEPTH_LARGE = 64;
  // ==========================================================
  // Register map: word index bits [5:3] pick the group, [2:0] the slot
  localparam logic [2:0] GRP_MISC = 3'h0;
  localparam logic [2:0] GRP_CTL = 3'h1;
  localparam logic [2:0] GRP_CMD = 3'h2;
  localparam logic [2:0] GRP_STS = 3'h3;
  localparam logic [2:0] GRP_DAT = 3'h4;
  localparam logic [2:0] SLOT_FUNC = 3'h0;
  localparam logic [2:0] SLOT_WARN = 3'h1;
  localparam logic [2:0] SLOT_NONE = 3'h7;
  // ==========================================================
  // Fields and reset values
  localparam int FUNC_EN_BIT = 7;
  localparam int CMD_FLUSH_BIT = 0;
  localparam int CMD_LAST_BIT = 1;
  localparam int CMD_THR_LSB = 8;
  localparam logic [7:0] CTL_MASK_EP0 = 8'hdf;
  localparam logic [7:0] CTL_MASK_EPN = 8'h3f;
  localparam logic [7:0] FUNC_ADDR_RST = 8'h00;
  localparam logic [6:0] THR_RST = 7'h00;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [6:0] addr;
    logic [3:0] ep;
    logic dir_in;
  } token_type;
  typedef struct packed {
    logic dir_tx;
    logic dflt_acc;
    logic iso;
    logic en;
    logic [3:0] num;
  } ep_ctl_type;
endpackage

/* logic/usb_endpoint_fifo_array.sv */
module usb_endpoint_fifo_array #(
  parameter int DEPTH_EP0_P = ep_fifo_pkg::DEPTH_EP0,
  parameter int DEPTH_SMALL_P = ep_fifo_pkg::DEPTH_SMALL,
  parameter int DEPTH_LARGE_P = ep_fifo_pkg::DEPTH_LARGE
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Token decode from the serial engine
  input wire logic tok_valid_i,
  input wire ep_fifo_pkg::token_type tok_i,
  output logic tok_match_o,
  output logic [2:0] tok_ep_o,
  // Transmit byte stream
  input wire logic tx_req_i,
  input wire logic tx_done_i,
  input wire logic tx_err_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_eop_o,
  output logic tx_underrun_o,
  // Receive byte stream
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_end_i,
  input wire logic rx_err_i,
  output logic rx_overrun_o
);
  import ep_fifo_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ==========================================================
  // Helpers
  function automatic int slot_size(input int s);
    return (s == 0) ? DEPTH_EP0_P :
           (s >= 5) ? DEPTH_LARGE_P : DEPTH_SMALL_P;
  endfunction

  // Pointers count modulo twice the size; the bit above the slot address is the lap
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p,
                                               input int s);
    return (p + PTR_W'(1)) & PTR_W'(2 * slot_size(s) - 1);
  endfunction

  function automatic logic [ADDR_W-1:0] mem_addr(
      input logic [PTR_W-1:0] p, input int s);
    return p[ADDR_W-1:0] & ADDR_W'(slot_size(s) - 1);
  endfunction

  // Lowest set bit wins
  function automatic logic [2:0] first_slot(input logic [NUM_FIFO-1:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NUM_FIFO - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // Depths must be powers of two that fit the shared array
  if (DEPTH_EP0_P < 2 || DEPTH_SMALL_P < 2 || DEPTH_LARGE_P < 2 ||
      DEPTH_EP0_P > MEM_DEPTH || DEPTH_SMALL_P > MEM_DEPTH ||
      DEPTH_LARGE_P > MEM_DEPTH ||
      (DEPTH_EP0_P & (DEPTH_EP0_P - 1)) != 0 ||
      (DEPTH_SMALL_P & (DEPTH_SMALL_P - 1)) != 0 ||
      (DEPTH_LARGE_P & (DEPTH_LARGE_P - 1)) != 0) begin : g_bad_depth
    $error("FIFO depth parameter unusable");
  end

  // ==========================================================
  // State
  logic [7:0] func_addr_r;
  ep_ctl_type ctl_r [NUM_FIFO];
  logic [6:0] thr_r [NUM_FIFO];
  logic [NUM_FIFO-1:0] last_r;
  logic [NUM_FIFO-1:0] err_r;
  logic [NUM_FIFO-1:0] done_r;
  logic [NUM_FIFO-1:0] warn_r;
  logic [PTR_W-1:0] wp_r [NUM_FIFO];
  logic [PTR_W-1:0] rp_r [NUM_FIFO];
  logic [7:0] mem_r [NUM_FIFO][MEM_DEPTH];
  logic active_r;
  logic dir_in_r;
  logic [2:0] sel_r;
  logic [PTR_W-1:0] start_r;
  logic pop_seen_r;

  // Per-slot wires
  logic [NUM_FIFO-1:0] is_tx;
  logic [NUM_FIFO-1:0] empty;
  logic [NUM_FIFO-1:0] full;
  logic [NUM_FIFO-1:0] elig;
  logic [NUM_FIFO-1:0] flush;
  logic [NUM_FIFO-1:0] fw_push;
  logic [NUM_FIFO-1:0] fw_pop;
  logic [NUM_FIFO-1:0] sie_push;
  logic [NUM_FIFO-1:0] sie_pop;
  logic [NUM_FIFO-1:0] rx_abort;
  logic [NUM_FIFO-1:0] tx_retry;
  logic [NUM_FIFO-1:0] sts_rd;
  logic [NUM_FIFO-1:0] err_set;
  logic [NUM_FIFO-1:0] done_set;
  logic [NUM_FIFO-1:0] warn_nxt;
  logic [PTR_W-1:0] cnt [NUM_FIFO];
  logic [31:0] ctl_word [NUM_FIFO];
  logic [31:0] cmd_word [NUM_FIFO];
  logic [31:0] sts_word [NUM_FIFO];
  logic [31:0] dat_word [NUM_FIFO];

  // ==========================================================
  // Bus decode; effects land on the edge where ack is high
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_do = bus_req & wb_ack_o;
  wire wr_do = bus_do & wb_we_i;
  wire rd_do = bus_do & ~wb_we_i;
  wire [2:0] grp = wb_adr_i[7:5];
  wire [2:0] slot = wb_adr_i[4:2];
  wire slot_ok = slot != SLOT_NONE;
  wire [31:0] rd_word =
    (grp == GRP_MISC && slot == SLOT_FUNC) ? {24'h00_0000, func_addr_r} :
    (grp == GRP_MISC && slot == SLOT_WARN) ? {25'h000_0000, warn_r} :
    !slot_ok ? 32'h0000_0000 :
    (grp == GRP_CTL) ? ctl_word[slot] :
    (grp == GRP_CMD) ? cmd_word[slot] :
    (grp == GRP_STS) ? sts_word[slot] :
    (grp == GRP_DAT) ? dat_word[slot] : 32'h0000_0000;

  // Token address check; function address shared by all slots, default address for slot 0 only
  wire func_hit = func_addr_r[FUNC_EN_BIT] & (tok_i.addr == func_addr_r[6:0]);
  wire dflt_hit = ctl_r[0].dflt_acc & (tok_i.addr == 7'h00);
  wire tok_hit = |elig;
  wire [2:0] tok_pick = first_slot(elig);

  // Active-packet selections
  wire pkt_in = active_r & dir_in_r;
  wire pkt_out = active_r & ~dir_in_r;
  wire sel_empty = empty[sel_r];
  wire sel_full = full[sel_r];
  wire sel_last = last_r[sel_r];
  wire [7:0] sel_byte = mem_r[sel_r][mem_addr(rp_r[sel_r], int'(sel_r))];

  // ==========================================================
  // Per-slot FIFO logic
  for (genvar s = 0; s < NUM_FIFO; s++) begin : g_slot
    localparam int SZ = slot_size(s);
    logic [PTR_W-1:0] wp_nxt;
    logic [PTR_W-1:0] rp_nxt;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W-1:0] free;
    logic [PTR_W-1:0] cnt_rep;
    wire hit_slot = slot == 3'(s);
    wire on_sel = sel_r == 3'(s);

    // Level and flags; the lap bit separates full from empty
    assign cnt[s] = (wp_r[s] - rp_r[s]) & PTR_W'(2 * SZ - 1);
    assign empty[s] = cnt[s] == '0;
    assign full[s] = cnt[s] == PTR_W'(SZ);
    assign free = PTR_W'(SZ) - cnt[s];
    assign is_tx[s] = (s == 0) ? ctl_r[0].dir_tx : (s % 2 == 1);

    // Token eligibility; direction keeps shared numbers apart
    assign elig[s] = ctl_r[s].en & (ctl_r[s].num == tok_i.ep) &
                     (func_hit | (s == 0 && dflt_hit)) &
                     (tok_i.dir_in == is_tx[s]) &
                     (~ctl_r[s].iso |
                      (tok_i.dir_in ? ~empty[s] : ~full[s]));

    // Firmware side
    assign flush[s] = wr_do & (grp == GRP_CMD) & hit_slot & wb_sel_i[0] &
                      wb_dat_i[CMD_FLUSH_BIT];
    assign fw_push[s] = wr_do & (grp == GRP_DAT) & hit_slot & wb_sel_i[0] &
                        is_tx[s] & ~full[s];
    assign fw_pop[s] = rd_do & (grp == GRP_DAT) & hit_slot & ~is_tx[s] &
                       ~empty[s];
    assign sts_rd[s] = rd_do & (grp == GRP_STS) & hit_slot;

    // Serial engine side; a full receiver takes nothing more
    assign sie_pop[s] = pkt_in & on_sel & tx_req_i & ~empty[s];
    assign sie_push[s] = pkt_out & on_sel & rx_valid_i & ~full[s];
    assign rx_abort[s] = pkt_out & on_sel & rx_end_i & rx_err_i;
    assign tx_retry[s] = (s == 0) & pkt_in & on_sel & tx_err_i;
    assign err_set[s] = on_sel & ((pkt_in & tx_req_i & empty[s] &
                                   ~last_r[s]) |
                                  (pkt_out & rx_valid_i & full[s]));
    assign done_set[s] = on_sel & ((pkt_in & tx_done_i) |
                                   (pkt_out & rx_end_i & ~rx_err_i));

    // Warnings on pending level or remaining space
    assign warn_nxt[s] = (s == 0) ? 1'b0 :
                         is_tx[s] ? (cnt[s] <= thr_r[s]) :
                         (free <= thr_r[s]);

    // Pointer updates; flush has priority
    assign wp_nxt = flush[s] ? '0 :
                    rx_abort[s] ? (pop_seen_r ? rp_r[s] : start_r) :
                    (fw_push[s] | sie_push[s]) ? ptr_inc(wp_r[s], s) :
                    wp_r[s];
    assign rp_nxt = flush[s] ? '0 :
                    tx_retry[s] ? start_r :
                    (fw_pop[s] | sie_pop[s]) ? ptr_inc(rp_r[s], s) :
                    rp_r[s];

    // Empty reads repeat the byte behind the read pointer
    assign rd_ptr = empty[s] ? rp_r[s] - PTR_W'(1) : rp_r[s];
    assign cnt_rep = is_tx[s] ? free : cnt[s];
    assign ctl_word[s] = {24'h00_0000, ctl_r[s]};
    assign cmd_word[s] = {17'h0_0000, thr_r[s], 6'h00, last_r[s], 1'b0};
    assign sts_word[s] = {22'h00_0000, done_r[s], err_r[s], 1'b0, cnt_rep};
    assign dat_word[s] = {24'h00_0000, mem_r[s][mem_addr(rd_ptr, s)]};

    // Pointers and sticky flags; a set beats a status-read clear
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        wp_r[s] <= '0;
        rp_r[s] <= '0;
        err_r[s] <= 1'b0;
        done_r[s] <= 1'b0;
        warn_r[s] <= 1'b0;
      end else begin
        wp_r[s] <= wp_nxt;
        rp_r[s] <= rp_nxt;
        err_r[s] <= err_set[s] | (err_r[s] & ~sts_rd[s]);
        done_r[s] <= done_set[s] | (done_r[s] & ~sts_rd[s]);
        warn_r[s] <= warn_nxt[s];
      end
    end

    // Configuration registers
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ctl_r[s] <= '0;
        thr_r[s] <= THR_RST;
        last_r[s] <= 1'b0;
      end else begin
        if (wr_do && grp == GRP_CTL && hit_slot && wb_sel_i[0]) begin
          ctl_r[s] <= ep_ctl_type'(wb_dat_i[7:0] &
                      ((s == 0) ? CTL_MASK_EP0 : CTL_MASK_EPN));
        end
        if (wr_do && grp == GRP_CMD && hit_slot && wb_sel_i[1]) begin
          thr_r[s] <= wb_dat_i[CMD_THR_LSB +: 7];
        end
        // Firmware setting last wins over end of packet
        if (wr_do && grp == GRP_CMD && hit_slot && wb_sel_i[0]) begin
          last_r[s] <= wb_dat_i[CMD_LAST_BIT];
        end else if (pkt_in && on_sel && tx_done_i) begin
          last_r[s] <= 1'b0;
        end
      end
    end

    // Slot-local checks
    flush_zero_a: assert property (flush[s] |=> empty[s] &&
                                   wp_r[s] == '0)
      else $error("flush did not empty the FIFO");
    full_drop_a: assert property (
        fw_push[s] == 1'b0 && wr_do && grp == GRP_DAT && hit_slot &&
        is_tx[s] && full[s] && !sie_pop[s] |=> full[s])
      else $error("write to full transmit FIFO was taken");
    level_bound_a: assert property (cnt[s] <= PTR_W'(SZ))
      else $error("FIFO level beyond its size");
    rx_drop_a: assert property (
        rx_abort[s] && !pop_seen_r && !flush[s] |=>
        wp_r[s] == $past(start_r) && !done_r[s] ||
        $past(done_r[s]))
      else $error("bad OUT packet was kept");
  end

  // ==========================================================
  // Packet memory: firmware fills transmit, engine fills receive
  wire [2:0] fw_slot = slot;
  always_ff @(posedge clk_i) begin
    if (|fw_push) begin
      mem_r[fw_slot][mem_addr(wp_r[fw_slot], int'(fw_slot))] <=
        wb_dat_i[7:0];
    end
    if (|sie_push) begin
      mem_r[sel_r][mem_addr(wp_r[sel_r], int'(sel_r))] <= rx_data_i;
    end
  end

  // ==========================================================
  // Bus slave: ack one cycle after the request, data registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      func_addr_r <= FUNC_ADDR_RST;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req && !wb_ack_o) begin
        wb_dat_o <= rd_word;
      end
      if (wr_do && grp == GRP_MISC && slot == SLOT_FUNC && wb_sel_i[0]) begin
        func_addr_r <= wb_dat_i[7:0];
      end
    end
  end

  // ==========================================================
  // Token routing; unmatched tokens leave the block idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_r <= 1'b0;
      dir_in_r <= 1'b0;
      sel_r <= 3'h0;
      start_r <= '0;
      pop_seen_r <= 1'b0;
      tok_match_o <= 1'b0;
      tok_ep_o <= 3'h0;
    end else begin
      tok_match_o <= tok_valid_i & tok_hit;
      if (tok_valid_i) begin
        active_r <= tok_hit;
        dir_in_r <= tok_i.dir_in;
        sel_r <= tok_pick;
        tok_ep_o <= tok_pick;
        start_r <= tok_i.dir_in ? rp_r[tok_pick] : wp_r[tok_pick];
      end else if (pkt_in && (tx_done_i || tx_err_i)) begin
        active_r <= 1'b0;
      end else if (pkt_out && rx_end_i) begin
        active_r <= 1'b0;
      end
      // Draining during reception makes rollback unsafe
      pop_seen_r <= ~tok_valid_i & (pop_seen_r | fw_pop[sel_r]);
    end
  end

  // ==========================================================
  // Byte answers to the engine, one cycle after each request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
      tx_eop_o <= 1'b0;
      tx_underrun_o <= 1'b0;
      rx_overrun_o <= 1'b0;
    end else begin
      tx_valid_o <= pkt_in & tx_req_i & ~sel_empty;
      tx_eop_o <= pkt_in & tx_req_i & sel_empty & sel_last;
      tx_underrun_o <= pkt_in & tx_req_i & sel_empty & ~sel_last;
      rx_overrun_o <= pkt_out & rx_valid_i & sel_full;
      if (pkt_in && tx_req_i && !sel_empty) begin
        tx_data_o <= sel_byte;
      end
    end
  end

  // ==========================================================
  // Checks
  sequence ep0_err_s;
    pkt_in && sel_r == 3'h0 && tx_err_i && !flush[0];
  endsequence

  sequence tok_taken_s;
    tok_valid_i && !elig[0] && elig[2] && elig[4];
  endsequence

  addr_gate_a: assert property (
      tok_valid_i && !func_hit && !dflt_hit |=> !tok_match_o && !active_r)
    else $error("token taken without address match");
  no_match_a: assert property (
      tok_valid_i && elig == '0 |=> !tok_match_o)
    else $error("token matched no enabled endpoint");
  lower_pick_a: assert property (
      tok_taken_s |=> tok_match_o && tok_ep_o == 3'h2 && sel_r == 3'h2)
    else $error("higher endpoint chosen over lower");
  dir_split_a: assert property (
      tok_valid_i && tok_i.dir_in |=> !tok_match_o || is_tx[tok_ep_o])
    else $error("IN token routed to a receive FIFO");
  ep0_retry_a: assert property (
      ep0_err_s |=> rp_r[0] == $past(start_r) ##1 !active_r)
    else $error("endpoint zero data not kept for retry");
  under_flag_a: assert property (
      pkt_in && tx_req_i && sel_empty && !sel_last |=>
      tx_underrun_o && !tx_valid_o && err_r[$past(sel_r)])
    else $error("underrun not reported");
  tx_free_a: assert property (
      wb_ack_o && !wb_we_i && grp == GRP_STS && slot == 3'h5 &&
      $past(bus_req && !wb_ack_o && is_tx[5] && !fw_pop[5] &&
            !sie_pop[5] && !sie_push[5]) |->
      wb_dat_o[6:0] == 7'h40 - $past(cnt[5]))
    else $error("transmit free count wrong");
  warn_tx_a: assert property (
      cnt[1] <= thr_r[1] && $stable(cnt[1]) && $stable(thr_r[1]) |=>
      warn_r[1])
    else $error("transmit warning missing");
  ep0_iso_a: assert property (!ctl_r[0].iso)
    else $error("endpoint zero marked isochronous");
endmodule
